// ---- hw/status_pkg.sv ----
// constants shared by the sequence and trigger status logic
package status_pkg;
	localparam int                STAT_W            = 16;
	// register selectors on the command port
	localparam logic [3:0]        SEL_SEQ_COND      = 4'h0;
	localparam logic [3:0]        SEL_SEQ_RISE      = 4'h1;
	localparam logic [3:0]        SEL_SEQ_FALL      = 4'h2;
	localparam logic [3:0]        SEL_SEQ_EVENT     = 4'h3;
	localparam logic [3:0]        SEL_SEQ_MASK      = 4'h4;
	localparam logic [3:0]        SEL_TRIG_COND     = 4'h5;
	localparam logic [3:0]        SEL_TRIG_RISE     = 4'h6;
	localparam logic [3:0]        SEL_TRIG_FALL     = 4'h7;
	localparam logic [3:0]        SEL_TRIG_EVENT    = 4'h8;
	localparam logic [3:0]        SEL_TRIG_MASK     = 4'h9;
	// used bits of each set
	localparam logic [15:0]       SEQ_USED          = 16'h0006;
	localparam logic [15:0]       TRIG_USED         = 16'h0002;
	localparam int                ARM_LAYER_BIT     = 1;
	localparam int                SCAN_LAYER_BIT    = 2;
	localparam int                MEASURE_LAYER_BIT = 1;
	// reset values
	localparam logic [15:0]       RISE_RESET        = 16'hffff;
	localparam logic [15:0]       FALL_RESET        = 16'h0000;
	localparam logic [15:0]       MASK_RESET        = 16'h0000;
	localparam logic [15:0]       EVENT_RESET       = 16'h0000;
endpackage : status_pkg

// ---- hw/status_set.sv ----
// one condition / transition filter / event latch / enable mask set
`timescale 1ns/1ps
module status_set
	import status_pkg::*;
#(
	parameter logic [15:0] USED = 16'hffff
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [15:0] cond,
	input  wire logic        wr_rise,
	input  wire logic        wr_fall,
	input  wire logic        wr_mask,
	input  wire logic [15:0] wdata,
	input  wire logic        ev_clear,
	input  wire logic        preset,
	output logic      [15:0] cond_q,
	output logic      [15:0] rise_q,
	output logic      [15:0] fall_q,
	output logic      [15:0] event_q,
	output logic      [15:0] mask_q,
	output logic             summary
);
	logic [15:0] cond_r, rise_r, fall_r, event_r, mask_r;
	logic [15:0] rise_nxt, fall_nxt, event_nxt, mask_nxt, hit;

	always_comb begin
		hit       = USED & ((~cond_r & cond & rise_r) | (cond_r & ~cond & fall_r)); // RULE_06 RULE_07 RULE_16
		rise_nxt  = preset ? RISE_RESET : (wr_rise ? wdata : rise_r); // RULE_09
		fall_nxt  = preset ? FALL_RESET : (wr_fall ? wdata : fall_r); // RULE_09
		mask_nxt  = wr_mask ? wdata : mask_r; // RULE_03 RULE_14
		// a new edge in the clearing cycle survives the clear
		event_nxt = (ev_clear ? EVENT_RESET : event_r) | hit; // RULE_01 RULE_10 RULE_12
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cond_r  <= 16'h0000;
			rise_r  <= RISE_RESET;
			fall_r  <= FALL_RESET;
			event_r <= EVENT_RESET;
			mask_r  <= MASK_RESET;
		end else begin
			cond_r  <= cond;
			rise_r  <= rise_nxt;
			fall_r  <= fall_nxt;
			event_r <= event_nxt;
			mask_r  <= mask_nxt;
		end
	end

	assign cond_q  = cond_r & USED; // RULE_17
	assign rise_q  = rise_r & USED;
	assign fall_q  = fall_r & USED;
	assign event_q = event_r;
	assign mask_q  = mask_r & USED;
	assign summary = |(event_r & mask_r & USED); // RULE_02 RULE_11 RULE_13 RULE_17
endmodule : status_set

// ---- hw/arm_trigger_event_status.sv ----
// sequence and trigger status register sets with summary outputs
//////////////////////////////////////////////////////////////////////////////
// How it works
// RULE_01 - sequence event latch clears on reset, clear-status, and its own read
// RULE_02 - masked OR of sequence events drives arm-condition bit B1
// RULE_03 - sequence mask is read/write, reads harmless, resets to zero
// RULE_04 - trigger set is 16 bits wide with only bit B1 in use
// RULE_05 - trigger condition is read-only live copy of measure-layer state in B1
// RULE_06 - rising filter bit lets a 0-to-1 condition change set the event
// RULE_07 - falling filter bit lets a 1-to-0 change set it; both may be on
// RULE_08 - trigger filter reads never change the filters
// RULE_09 - reset or preset sets rising filters to all ones, falling to zero
// RULE_10 - trigger event bits latch until cleared; software only reads them
// RULE_11 - masked OR of trigger events drives operation-condition bit B5
// RULE_12 - trigger event latch clears on reset, clear-status, and its own read
// RULE_13 - mask bit B1 zero blocks the trigger summary, one passes it
// RULE_14 - trigger mask is read/write, reads harmless, resets to zero
// RULE_15 - sequence bit B1 reports arm layer, bit B2 reports scan layer
// RULE_16 - sequence events come from their own edge filters, then latch
// RULE_17 - unused bits read zero and never reach a summary
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module arm_trigger_event_status
	import status_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        in_arm_layer,
	input  wire logic        in_scan_layer,
	input  wire logic        measure_layer_flag,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [3:0]  reg_sel,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        clear_status,
	input  wire logic        status_preset,
	output logic      [15:0] reg_rdata,
	output logic             reg_rvalid,
	output logic             arm_cond_b1,
	output logic             oper_cond_b5
);
	// layer flags come from the sequencer, possibly another domain
	logic [2:0] lay_s1_r, lay_s2_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			lay_s1_r <= 3'h0;
			lay_s2_r <= 3'h0;
		end else begin
			lay_s1_r <= {measure_layer_flag, in_scan_layer, in_arm_layer};
			lay_s2_r <= lay_s1_r;
		end
	end

	logic [15:0] seq_cond, trig_cond;
	always_comb begin
		seq_cond                    = 16'h0000;
		seq_cond[ARM_LAYER_BIT]     = lay_s2_r[0]; // RULE_15
		seq_cond[SCAN_LAYER_BIT]    = lay_s2_r[1]; // RULE_15
		trig_cond                   = 16'h0000;
		trig_cond[MEASURE_LAYER_BIT] = lay_s2_r[2]; // RULE_04 RULE_05
	end

	//////////////////////////////////////////////////////////////////////////
	logic wr_en, rd_en;
	assign wr_en = reg_wr & ~reg_rd;
	assign rd_en = reg_rd;

	// destructive reads decoded once, shared by the checks below
	logic rd_seq_ev, rd_trig_ev;
	assign rd_seq_ev  = rd_en && reg_sel == SEL_SEQ_EVENT;
	assign rd_trig_ev = rd_en && reg_sel == SEL_TRIG_EVENT;

	logic [15:0] sc_q, sr_q, sf_q, se_q, sm_q, tc_q, tr_q, tf_q, te_q, tm_q;
	logic        seq_sum, trig_sum;

	status_set #(.USED(SEQ_USED)) seq_set (
		.clk      (clk),
		.rst      (rst),
		.cond     (seq_cond),
		.wr_rise  (wr_en && reg_sel == SEL_SEQ_RISE),
		.wr_fall  (wr_en && reg_sel == SEL_SEQ_FALL),
		.wr_mask  (wr_en && reg_sel == SEL_SEQ_MASK), // RULE_03
		.wdata    (reg_wdata),
		.ev_clear (clear_status | (rd_en && reg_sel == SEL_SEQ_EVENT)), // RULE_01
		.preset   (status_preset),
		.cond_q   (sc_q),
		.rise_q   (sr_q),
		.fall_q   (sf_q),
		.event_q  (se_q),
		.mask_q   (sm_q),
		.summary  (seq_sum)
	);

	status_set #(.USED(TRIG_USED)) trig_set (
		.clk      (clk),
		.rst      (rst),
		.cond     (trig_cond),
		.wr_rise  (wr_en && reg_sel == SEL_TRIG_RISE),
		.wr_fall  (wr_en && reg_sel == SEL_TRIG_FALL),
		.wr_mask  (wr_en && reg_sel == SEL_TRIG_MASK), // RULE_14
		.wdata    (reg_wdata),
		.ev_clear (clear_status | (rd_en && reg_sel == SEL_TRIG_EVENT)), // RULE_12
		.preset   (status_preset),
		.cond_q   (tc_q),
		.rise_q   (tr_q),
		.fall_q   (tf_q),
		.event_q  (te_q),
		.mask_q   (tm_q),
		.summary  (trig_sum)
	);

	//////////////////////////////////////////////////////////////////////////
	// read data registered so a destructive read returns the pre-clear value
	logic [15:0] rdata_r, rdata_nxt;
	logic        rvalid_r, rvalid_nxt, arm_r, arm_nxt, op_r, op_nxt;

	always_comb begin
		rvalid_nxt = rd_en;
		rdata_nxt  = rdata_r;
		if (rd_en) begin
			case (reg_sel)
				SEL_SEQ_COND:   rdata_nxt = sc_q;
				SEL_SEQ_RISE:   rdata_nxt = sr_q;
				SEL_SEQ_FALL:   rdata_nxt = sf_q;
				SEL_SEQ_EVENT:  rdata_nxt = se_q;
				SEL_SEQ_MASK:   rdata_nxt = sm_q;
				SEL_TRIG_COND:  rdata_nxt = tc_q; // RULE_05
				SEL_TRIG_RISE:  rdata_nxt = tr_q; // RULE_08
				SEL_TRIG_FALL:  rdata_nxt = tf_q; // RULE_08
				SEL_TRIG_EVENT: rdata_nxt = te_q; // RULE_10
				SEL_TRIG_MASK:  rdata_nxt = tm_q;
				default:        rdata_nxt = 16'h0000; // RULE_17
			endcase
		end
		arm_nxt = seq_sum; // RULE_02
		op_nxt  = trig_sum; // RULE_11
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_r  <= 16'h0000;
			rvalid_r <= 1'b0;
			arm_r    <= 1'b0;
			op_r     <= 1'b0;
		end else begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			arm_r    <= arm_nxt;
			op_r     <= op_nxt;
		end
	end

	assign reg_rdata    = rdata_r;
	assign reg_rvalid   = rvalid_r;
	assign arm_cond_b1  = arm_r;
	assign oper_cond_b5 = op_r;

	//////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// sequence set: clearing, summary and mask
	a_seq_read_clear: assert property ( // RULE_01
		(rd_seq_ev && seq_set.hit == 16'h0000) |=> se_q == 16'h0000)
		else $error("sequence event read did not clear");

	a_seq_cls_clear: assert property ( // RULE_01
		(clear_status && seq_set.hit == 16'h0000) |=> se_q == 16'h0000)
		else $error("clear status left sequence events");

	a_seq_mask_sum: assert property ( // RULE_02
		((se_q & sm_q) != 16'h0000) |=> arm_cond_b1)
		else $error("arm summary missing");

	a_seq_sum_low: assert property ( // RULE_02
		((se_q & sm_q) == 16'h0000) |=> !arm_cond_b1)
		else $error("arm summary without enabled event");

	a_seq_mask_read: assert property ( // RULE_03
		reg_rd |=> $stable(sm_q))
		else $error("sequence mask changed by read");

	a_seq_mask_write: assert property ( // RULE_03
		(wr_en && reg_sel == SEL_SEQ_MASK) |=> sm_q == ($past(reg_wdata) & SEQ_USED))
		else $error("sequence mask write lost");

	// trigger set: width, live condition and edge filters; filter preset of both sets
	a_trig_cond_bits: assert property ( // RULE_04
		((tc_q | tr_q | tf_q) & ~TRIG_USED) == 16'h0000)
		else $error("trigger set uses more than bit one");

	a_trig_cond_live: assert property ( // RULE_05
		!$past(rst) |-> tc_q[MEASURE_LAYER_BIT] == $past(lay_s2_r[2]))
		else $error("trigger condition not following layer flag");

	a_trig_rise_set: assert property ( // RULE_06
		(!trig_set.cond_r[1] && trig_cond[1] && trig_set.rise_r[1]) |=> te_q[1])
		else $error("rising edge not latched");

	a_trig_fall_set: assert property ( // RULE_07
		(trig_set.cond_r[1] && !trig_cond[1] && trig_set.fall_r[1]) |=> te_q[1])
		else $error("falling edge not latched");

	a_trig_filter_read: assert property ( // RULE_08
		(reg_rd && !status_preset) |=> $stable(tr_q) && $stable(tf_q))
		else $error("filter changed by read");

	a_preset_filters: assert property ( // RULE_09
		status_preset |=> tr_q == TRIG_USED && tf_q == 16'h0000)
		else $error("preset did not restore filters");

	a_preset_seq: assert property ( // RULE_09
		status_preset |=> sr_q == SEQ_USED && sf_q == 16'h0000)
		else $error("preset did not restore sequence filters");

	// trigger set: latch, clear, summary and mask
	a_trig_latch_hold: assert property ( // RULE_10
		(te_q[1] && !clear_status && !rd_trig_ev) |=> te_q[1])
		else $error("trigger event dropped");

	a_trig_no_spurious: assert property ( // RULE_10
		(!te_q[1] && !trig_set.hit[1]) |=> !te_q[1])
		else $error("trigger event set without edge");

	a_trig_sel_refused: assert property ( // RULE_10
		(wr_en && (reg_sel == SEL_TRIG_COND || reg_sel == SEL_TRIG_EVENT) && !status_preset)
		|=> $stable(tr_q) && $stable(tf_q) && $stable(tm_q))
		else $error("write to read-only selector changed state");

	a_trig_sum_set: assert property ( // RULE_11
		((te_q & tm_q) != 16'h0000) |=> oper_cond_b5)
		else $error("trigger summary missing");

	a_op_sum_low: assert property ( // RULE_11
		((te_q & tm_q) == 16'h0000) |=> !oper_cond_b5)
		else $error("trigger summary without enabled event");

	a_trig_read_clear: assert property ( // RULE_12
		(rd_trig_ev && te_q[1]) |=> reg_rdata[1] && te_q[1] == $past(trig_set.hit[1]))
		else $error("trigger event read not returned and cleared");

	a_trig_cls_clear: assert property ( // RULE_12
		(clear_status && trig_set.hit == 16'h0000) |=> te_q == 16'h0000)
		else $error("clear status left trigger events");

	a_trig_masked_low: assert property ( // RULE_13
		(tm_q[1] == 1'b0) [*2] |-> !oper_cond_b5)
		else $error("masked trigger reached summary");

	a_trig_mask_read: assert property ( // RULE_14
		reg_rd |=> $stable(tm_q))
		else $error("trigger mask changed by read");

	a_trig_mask_write: assert property ( // RULE_14
		(wr_en && reg_sel == SEL_TRIG_MASK) |=> tm_q == ($past(reg_wdata) & TRIG_USED))
		else $error("trigger mask write lost");

	// sequence condition mapping, its own filters and latch
	a_seq_layer_map: assert property ( // RULE_15
		!$past(rst) |-> sc_q[ARM_LAYER_BIT] == $past(lay_s2_r[0])
		&& sc_q[SCAN_LAYER_BIT] == $past(lay_s2_r[1]))
		else $error("sequence condition bits misplaced");

	a_seq_rise_set: assert property ( // RULE_16
		(!seq_set.cond_r[2] && seq_cond[2] && seq_set.rise_r[2]) |=> se_q[2])
		else $error("sequence rising edge not latched");

	a_seq_fall_set: assert property ( // RULE_16
		(seq_set.cond_r[1] && !seq_cond[1] && seq_set.fall_r[1]) |=> se_q[1])
		else $error("sequence falling edge not latched");

	a_seq_latch_hold: assert property ( // RULE_16
		(se_q[2] && !clear_status && !rd_seq_ev) |=> se_q[2])
		else $error("sequence event dropped");

	// unused event and mask bits stay dark in both sets
	a_unused_zero: assert property ( // RULE_17
		(te_q & ~TRIG_USED) == 16'h0000 && (tm_q & ~TRIG_USED) == 16'h0000
		&& (se_q & ~SEQ_USED) == 16'h0000 && (sm_q & ~SEQ_USED) == 16'h0000)
		else $error("unused status bit visible");

	c_trig_rise: cover property ($rose(te_q[1]));
	c_trig_sum: cover property ($rose(oper_cond_b5));
	c_seq_sum: cover property ($rose(arm_cond_b1));
	c_read_clear: cover property (rd_trig_ev && te_q[1]);
	c_seq_read_clear: cover property (rd_seq_ev && se_q != 16'h0000);
endmodule : arm_trigger_event_status

// ---- bench/tb_top.sv ----
// self-checking bench for the sequence and trigger status sets
`timescale 1ns/1ps
module tb_top;
	import status_pkg::*;
	typedef struct packed {logic w; logic [3:0] sel; logic [15:0] d; logic [15:0] exp;} row_t;
	logic        clk                = 1'b0;
	logic        rst                = 1'b1;
	logic        in_arm_layer       = 1'b0;
	logic        in_scan_layer      = 1'b0;
	logic        measure_layer_flag = 1'b0;
	logic        reg_wr             = 1'b0;
	logic        reg_rd             = 1'b0;
	logic [3:0]  reg_sel            = 4'h0;
	logic [15:0] reg_wdata          = 16'h0000;
	logic        clear_status       = 1'b0;
	logic        status_preset      = 1'b0;
	logic [15:0] reg_rdata;
	logic        reg_rvalid;
	logic        arm_cond_b1;
	logic        oper_cond_b5;
	int          miscompares        = 0;
	int          checked            = 0;
	int          cycles             = 0;
	// write rows read back at the same selector; reads show only used bits
	row_t        rows [19]          = '{
		'{1'b0, SEL_SEQ_RISE, 16'h0000, 16'h0006}, '{1'b0, SEL_SEQ_FALL, 16'h0000, 16'h0000},
		'{1'b0, SEL_SEQ_EVENT, 16'h0000, 16'h0000}, '{1'b0, SEL_SEQ_MASK, 16'h0000, 16'h0000},
		'{1'b0, SEL_TRIG_COND, 16'h0000, 16'h0000}, '{1'b0, SEL_TRIG_RISE, 16'h0000, 16'h0002},
		'{1'b0, SEL_TRIG_FALL, 16'h0000, 16'h0000}, '{1'b0, SEL_TRIG_EVENT, 16'h0000, 16'h0000},
		'{1'b0, SEL_TRIG_MASK, 16'h0000, 16'h0000}, '{1'b0, 4'hc, 16'h0000, 16'h0000},
		'{1'b1, SEL_TRIG_MASK, 16'hffff, 16'h0002}, '{1'b0, SEL_TRIG_MASK, 16'h0000, 16'h0002},
		'{1'b1, SEL_TRIG_MASK, 16'h0000, 16'h0000}, '{1'b1, SEL_SEQ_MASK, 16'hffff, 16'h0006},
		'{1'b1, SEL_SEQ_MASK, 16'h0000, 16'h0000}, '{1'b1, SEL_TRIG_FALL, 16'hffff, 16'h0002},
		'{1'b0, SEL_TRIG_FALL, 16'h0000, 16'h0002}, '{1'b1, SEL_TRIG_COND, 16'hffff, 16'h0000},
		'{1'b1, 4'he, 16'hffff, 16'h0000}};

	arm_trigger_event_status DUT (
		.clk                (clk),
		.rst                (rst),
		.in_arm_layer       (in_arm_layer),
		.in_scan_layer      (in_scan_layer),
		.measure_layer_flag (measure_layer_flag),
		.reg_wr             (reg_wr),
		.reg_rd             (reg_rd),
		.reg_sel            (reg_sel),
		.reg_wdata          (reg_wdata),
		.clear_status       (clear_status),
		.status_preset      (status_preset),
		.reg_rdata          (reg_rdata),
		.reg_rvalid         (reg_rvalid),
		.arm_cond_b1        (arm_cond_b1),
		.oper_cond_b5       (oper_cond_b5)
	);

	always #5 clk = ~clk;
	//////////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	// run is under two hundred cycles; ceiling leaves wide margin
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic wr(input logic [3:0] s, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_sel <= s;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// rvalid stands just after the taking edge, so look there
	task automatic rd(input logic [3:0] s, input logic [15:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_sel <= s;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check("rvalid", {15'h0000, reg_rvalid}, 16'h0001);
		check("rdata", reg_rdata, exp);
	endtask : rd

	task automatic pulse(input logic preset);
		@(posedge clk);
		clear_status <= ~preset;
		status_preset <= preset;
		@(posedge clk);
		clear_status <= 1'b0;
		status_preset <= 1'b0;
	endtask : pulse

	// two sync flops plus compare plus summary: five cycles settles all
	task automatic lay(input logic a, input logic s, input logic m);
		@(posedge clk);
		in_arm_layer <= a;
		in_scan_layer <= s;
		measure_layer_flag <= m;
		cyc(5);
		#1;
	endtask : lay

	task automatic sums(input logic b1, input logic b5);
		check("arm_cond_b1", {15'h0000, arm_cond_b1}, {15'h0000, b1});
		check("oper_cond_b5", {15'h0000, oper_cond_b5}, {15'h0000, b5});
	endtask : sums
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(3);
		rst <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].w)
				wr(rows[i].sel, rows[i].d);
			rd(rows[i].sel, rows[i].exp);
		end
		pulse(1'b1);
		rd(SEL_TRIG_FALL, 16'h0000);
		rd(SEL_TRIG_RISE, 16'h0002);
		wr(SEL_TRIG_MASK, 16'h0002);
		lay(1'b0, 1'b0, 1'b1);
		sums(1'b0, 1'b1);
		rd(SEL_TRIG_COND, 16'h0002);
		rd(SEL_TRIG_EVENT, 16'h0002);
		rd(SEL_TRIG_EVENT, 16'h0000);
		cyc(2);
		#1;
		sums(1'b0, 1'b0);
		lay(1'b0, 1'b0, 1'b0);
		rd(SEL_TRIG_EVENT, 16'h0000);
		wr(SEL_TRIG_RISE, 16'h0000);
		wr(SEL_TRIG_FALL, 16'hffff);
		lay(1'b0, 1'b0, 1'b1);
		rd(SEL_TRIG_EVENT, 16'h0000);
		lay(1'b0, 1'b0, 1'b0);
		rd(SEL_TRIG_EVENT, 16'h0002);
		wr(SEL_TRIG_RISE, 16'hffff);
		lay(1'b0, 1'b0, 1'b1);
		rd(SEL_TRIG_EVENT, 16'h0002);
		wr(SEL_TRIG_MASK, 16'h0000);
		lay(1'b0, 1'b0, 1'b0);
		sums(1'b0, 1'b0);
		pulse(1'b0);
		rd(SEL_TRIG_EVENT, 16'h0000);
		wr(SEL_SEQ_MASK, 16'h0004);
		lay(1'b1, 1'b0, 1'b0);
		sums(1'b0, 1'b0);
		lay(1'b1, 1'b1, 1'b0);
		sums(1'b1, 1'b0);
		rd(SEL_SEQ_EVENT, 16'h0006);
		rd(SEL_SEQ_EVENT, 16'h0000);
		lay(1'b0, 1'b0, 1'b0);
		rd(SEL_SEQ_EVENT, 16'h0000);
		lay(1'b1, 1'b0, 1'b0);
		pulse(1'b0);
		rd(SEL_SEQ_EVENT, 16'h0000);
		wr(SEL_SEQ_MASK, 16'hffff);
		lay(1'b0, 1'b0, 1'b0);
		@(posedge clk);
		rst <= 1'b1;
		cyc(3);
		rst <= 1'b0;
		rd(SEL_SEQ_MASK, 16'h0000);
		sums(1'b0, 1'b0);
		finish_test();
	end
endmodule : tb_top
